// ===== include/smp_pkg.sv
// shared constants and types for the strap latch and mii pin role block
package smp_pkg;

    // ========================================================
    // register indexes (byte address is four times the index)
    localparam logic [5:0] IDX_CTRL = 6'h00;
    localparam logic [5:0] IDX_STRAP = 6'h10;
    localparam logic [5:0] IDX_MDIO = 6'h11;
    localparam logic [5:0] IDX_INT = 6'h1B;
    localparam logic [5:0] IDX_POL = 6'h1F;

    // ========================================================
    // field positions
    localparam int CTRL_DUPLEX_BIT = 8;
    localparam int CTRL_ISO_BIT = 10;
    localparam int POL_BIT = 9;
    localparam int INT_EN_LSB = 8;
    localparam int N_EVT = 3;
    localparam int EVT_TX_START = 0;
    localparam int EVT_TX_END = 1;
    localparam int EVT_LATCHED = 2;
    localparam int STRAP_RSVD_BIT = 8;

    // ========================================================
    // reset values and fixed values
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [N_EVT-1:0] INT_EN_RESET = 3'h0;
    localparam logic POL_RESET = 1'b0;
    localparam logic [1:0] ADDR_HI_FIXED = 2'h0;

    // ========================================================
    // timing: two sync stages plus one settle cycle before latching
    localparam logic [1:0] SETTLE_LAST = 2'h2;

    // ========================================================
    // interface selection codes
    localparam logic [2:0] MODE_MII = 3'h0;
    localparam logic [2:0] MODE_RMII = 3'h1;
    localparam logic [2:0] MODE_SMII = 3'h2;
    localparam logic [2:0] MODE_RSVD_A = 3'h3;
    localparam logic [2:0] MODE_MII_PRE = 3'h4;
    localparam logic [2:0] MODE_RMII_B2B = 3'h5;
    localparam logic [2:0] MODE_MII_B2B = 3'h6;
    localparam logic [2:0] MODE_RSVD_B = 3'h7;

    // ========================================================
    // types
    typedef enum logic [1:0] {
        ST_SETTLE = 2'b01,
        ST_RUN = 2'b10
    } smp_state_t;

    typedef struct packed {
        logic dv;
        logic er;
        logic [3:0] data;
    } smp_mii_rx_t;

    typedef struct packed {
        logic [4:0] addr;
        logic [2:0] iface;
    } smp_strap_t;

endpackage

// ===== rtl/smp_top.sv
// strap latch, mii pin roles, management capture and interrupt logic
`timescale 1ns/10ps
`default_nettype none

module smp_top #(
    parameter int CLK_HALF = 2
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // shared receive pins: strap in, mii out
    input wire smp_pkg::smp_mii_rx_t rx_pin_in,
    output smp_pkg::smp_mii_rx_t rx_pin_out,
    output logic rx_pin_oe,
    input wire logic [1:0] cfg_lo_pin,
    // transmit pins from the mac
    input wire logic txen_pin,
    input wire logic [3:0] txd_pin,
    // mii clocks
    output logic rxc_out,
    output logic txc_out,
    // management pins
    input wire logic mdc_pin,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    // interrupt
    output logic irq_out,
    // core side
    input wire smp_pkg::smp_mii_rx_t core_rx,
    output logic core_tx_en,
    output logic [3:0] core_tx_data,
    output logic [4:0] mgmt_bus_address,
    output logic [2:0] iface_select,
    output logic mode_reserved
);

    // ========================================================
    // functions

    // byte lanes to a write mask over the low half word
    function automatic logic [15:0] lane_mask(input logic [3:0] sel);
        lane_mask = {{8{sel[1]}}, {8{sel[0]}}};
    endfunction

    // reserved interface codes
    function automatic logic is_rsvd(input logic [2:0] code);
        is_rsvd = (code == smp_pkg::MODE_RSVD_A) || (code == smp_pkg::MODE_RSVD_B);
    endfunction

    // ========================================================
    // pin synchronisers, two flops each
    smp_pkg::smp_mii_rx_t rx_s1, rx_s2;
    logic [1:0] cfg_s1, cfg_s2;
    logic [4:0] tx_s1, tx_s2;
    logic [2:0] mg_s1, mg_s2;
    logic txen_d, mdc_d;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rx_s1 <= '0;
            rx_s2 <= '0;
            cfg_s1 <= 2'h0;
            cfg_s2 <= 2'h0;
            tx_s1 <= 5'h00;
            tx_s2 <= 5'h00;
            mg_s1 <= 3'h0;
            mg_s2 <= 3'h0;
            txen_d <= 1'b0;
            mdc_d <= 1'b0;
        end else begin
            rx_s1 <= rx_pin_in;
            rx_s2 <= rx_s1;
            cfg_s1 <= cfg_lo_pin;
            cfg_s2 <= cfg_s1;
            tx_s1 <= {txen_pin, txd_pin};
            tx_s2 <= tx_s1;
            mg_s1 <= {mdc_pin, mdio_in, 1'b0};
            mg_s2 <= mg_s1;
            txen_d <= tx_s2[4];
            mdc_d <= mg_s2[2];
        end
    end

    wire logic txen_rise = tx_s2[4] & ~txen_d;
    wire logic txen_fall = ~tx_s2[4] & txen_d;
    wire logic mdc_rise = mg_s2[2] & ~mdc_d;

    // ========================================================
    // strap phase state
    smp_pkg::smp_state_t state, next_state;
    logic [1:0] settle_cnt, next_settle_cnt;
    smp_pkg::smp_strap_t strap, next_strap;
    wire logic latch_now = (state == smp_pkg::ST_SETTLE) && (settle_cnt == smp_pkg::SETTLE_LAST);

    // wait for the sync pipeline to fill, then take the straps once
    always_comb begin
        next_state = state;
        next_settle_cnt = settle_cnt;
        next_strap = strap;
        case (state)
            smp_pkg::ST_SETTLE: begin
                next_settle_cnt = settle_cnt + 2'h1;
                if (latch_now) begin
                    next_state = smp_pkg::ST_RUN;
                    next_strap.addr = {smp_pkg::ADDR_HI_FIXED, rx_s2.data[1],
                                       rx_s2.data[2], rx_s2.data[3]};
                    next_strap.iface = {rx_s2.dv, cfg_s2};
                end
            end
            smp_pkg::ST_RUN: begin
                next_state = smp_pkg::ST_RUN;
            end
            default: begin
                next_state = smp_pkg::ST_SETTLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state <= smp_pkg::ST_SETTLE;
            settle_cnt <= 2'h0;
            strap <= '0;
        end else begin
            state <= next_state;
            settle_cnt <= next_settle_cnt;
            strap <= next_strap;
        end
    end

    // ========================================================
    // software registers and wishbone slave
    logic [15:0] ctrl, next_ctrl;
    logic [smp_pkg::N_EVT-1:0] int_stat, next_int_stat, int_en, next_int_en;
    logic pol, next_pol;
    logic [15:0] mdio_shift, next_mdio_shift;
    logic [31:0] next_dat;
    logic next_ack;
    logic [smp_pkg::N_EVT-1:0] evt;
    logic [15:0] wmask, wdat;
    wire logic [5:0] idx = wb_adr_i[7:2];
    wire logic wr_go = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

    always_comb begin
        wmask = lane_mask(wb_sel_i);
        wdat = wb_dat_i[15:0];
        evt = '0;
        evt[smp_pkg::EVT_TX_START] = txen_rise & ~ctrl[smp_pkg::CTRL_ISO_BIT];
        evt[smp_pkg::EVT_TX_END] = txen_fall & ~ctrl[smp_pkg::CTRL_ISO_BIT];
        evt[smp_pkg::EVT_LATCHED] = latch_now;
        next_ctrl = ctrl;
        next_int_en = int_en;
        next_pol = pol;
        next_int_stat = int_stat;
        next_mdio_shift = mdio_shift;
        // software writes commit on the edge that sees ack high
        if (wr_go && idx == smp_pkg::IDX_CTRL) begin
            next_ctrl = (ctrl & ~wmask) | (wdat & wmask);
        end
        if (wr_go && idx == smp_pkg::IDX_INT && wb_sel_i[1]) begin
            next_int_en = wdat[smp_pkg::INT_EN_LSB +: smp_pkg::N_EVT];
        end
        if (wr_go && idx == smp_pkg::IDX_POL && wb_sel_i[1]) begin
            next_pol = wdat[smp_pkg::POL_BIT];
        end
        if (wr_go && idx == smp_pkg::IDX_INT && wb_sel_i[0]) begin
            next_int_stat = int_stat & ~wdat[smp_pkg::N_EVT-1:0];
        end
        next_int_stat = next_int_stat | evt; // set wins over a same-cycle clear
        // straps override the control bits at the moment they are taken
        if (latch_now) begin
            next_ctrl[smp_pkg::CTRL_DUPLEX_BIT] = ~rx_s2.data[0];
            next_ctrl[smp_pkg::CTRL_ISO_BIT] = rx_s2.er;
        end
        // management data is taken on each management clock rise
        if (mdc_rise) begin
            next_mdio_shift = {mdio_shift[14:0], mg_s2[1]};
        end
        // single cycle ack, unmapped indexes read as zero
        next_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
        next_dat = 32'h0000_0000;
        case (idx)
            smp_pkg::IDX_CTRL: next_dat[15:0] = ctrl;
            smp_pkg::IDX_STRAP: begin
                next_dat[7:0] = strap;
                next_dat[smp_pkg::STRAP_RSVD_BIT] = is_rsvd(strap.iface);
            end
            smp_pkg::IDX_MDIO: next_dat[15:0] = mdio_shift;
            smp_pkg::IDX_INT: begin
                next_dat[smp_pkg::N_EVT-1:0] = int_stat;
                next_dat[smp_pkg::INT_EN_LSB +: smp_pkg::N_EVT] = int_en;
            end
            smp_pkg::IDX_POL: next_dat[smp_pkg::POL_BIT] = pol;
            default: next_dat = 32'h0000_0000;
        endcase
        if (!next_ack) begin
            next_dat = wb_dat_o;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl <= smp_pkg::CTRL_RESET;
            int_en <= smp_pkg::INT_EN_RESET;
            pol <= smp_pkg::POL_RESET;
            int_stat <= '0;
            mdio_shift <= 16'h0000;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            ctrl <= next_ctrl;
            int_en <= next_int_en;
            pol <= next_pol;
            int_stat <= next_int_stat;
            mdio_shift <= next_mdio_shift;
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
        end
    end

    // ========================================================
    // pin drivers, clocks and interrupt output
    logic [7:0] div_cnt, next_div_cnt;
    logic next_mclk, next_irq, next_oe;
    smp_pkg::smp_mii_rx_t next_rx_out;
    logic [4:0] next_core_tx;
    wire logic div_wrap = (div_cnt == 8'(CLK_HALF - 1));
    wire logic any_irq = |(int_stat & int_en);

    // drivers stay off until straps are taken, so they cannot corrupt them
    always_comb begin
        next_oe = (state == smp_pkg::ST_RUN) & ~ctrl[smp_pkg::CTRL_ISO_BIT];
        next_rx_out = next_oe ? core_rx : '0;
        next_core_tx = ctrl[smp_pkg::CTRL_ISO_BIT] ? 5'h00 : tx_s2;
        next_div_cnt = div_wrap ? 8'h00 : div_cnt + 8'h01;
        next_mclk = div_wrap ? ~rxc_out : rxc_out;
        next_irq = pol ? any_irq : ~any_irq;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rx_pin_oe <= 1'b0;
            rx_pin_out <= '0;
            core_tx_en <= 1'b0;
            core_tx_data <= 4'h0;
            div_cnt <= 8'h00;
            rxc_out <= 1'b0;
            txc_out <= 1'b0;
            irq_out <= 1'b1;
            mdio_out <= 1'b0;
            mdio_oe <= 1'b0;
            mgmt_bus_address <= 5'h00;
            iface_select <= 3'h0;
            mode_reserved <= 1'b0;
        end else begin
            rx_pin_oe <= next_oe;
            rx_pin_out <= next_rx_out;
            {core_tx_en, core_tx_data} <= next_core_tx;
            div_cnt <= next_div_cnt;
            rxc_out <= next_mclk;
            txc_out <= next_mclk;
            irq_out <= next_irq;
            mdio_out <= 1'b0;
            mdio_oe <= 1'b0;
            mgmt_bus_address <= strap.addr;
            iface_select <= strap.iface;
            mode_reserved <= is_rsvd(strap.iface);
        end
    end

    // ========================================================
    // assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    property p_addr_hi;
        mgmt_bus_address[4:3] == smp_pkg::ADDR_HI_FIXED;
    endproperty
    a_addr_hi: assert property (p_addr_hi) else $error("address high bits not zero");
    property p_addr_map;
        latch_now |=> ##1 mgmt_bus_address == {2'b00, $past(rx_s2.data[1], 2),
                                               $past(rx_s2.data[2], 2), $past(rx_s2.data[3], 2)};
    endproperty
    a_addr_map: assert property (p_addr_map) else $error("address strap wrong");
    property p_duplex;
        latch_now |=> ctrl[smp_pkg::CTRL_DUPLEX_BIT] == !$past(rx_s2.data[0]);
    endproperty
    a_duplex: assert property (p_duplex) else $error("duplex strap wrong");
    property p_iface;
        latch_now |=> ##1 iface_select == {$past(rx_s2.dv, 2), $past(cfg_s2, 2)};
    endproperty
    a_iface: assert property (p_iface) else $error("interface strap wrong");
    property p_iso;
        latch_now |=> ctrl[smp_pkg::CTRL_ISO_BIT] == $past(rx_s2.er)
            ##1 rx_pin_oe != ctrl[smp_pkg::CTRL_ISO_BIT];
    endproperty
    a_iso: assert property (p_iso) else $error("isolate strap wrong");
    property p_quiet_settle;
        state == smp_pkg::ST_SETTLE |=> !rx_pin_oe;
    endproperty
    a_quiet_settle: assert property (p_quiet_settle) else $error("pins driven early");
    property p_rx_drive;
        rx_pin_oe |-> rx_pin_out == $past(core_rx);
    endproperty
    a_rx_drive: assert property (p_rx_drive) else $error("rx pins wrong");
    property p_tx_iso;
        ctrl[smp_pkg::CTRL_ISO_BIT] |=> !core_tx_en;
    endproperty
    a_tx_iso: assert property (p_tx_iso) else $error("tx passed while isolated");
    property p_clk;
        div_wrap |=> rxc_out != $past(rxc_out) && txc_out == rxc_out;
    endproperty
    a_clk: assert property (p_clk) else $error("mii clock not toggling");
    property p_mdio;
        mdc_rise |=> mdio_shift[0] == $past(mg_s2[1]);
    endproperty
    a_mdio: assert property (p_mdio) else $error("mdio bit not taken");
    property p_irq;
        any_irq && !pol && $stable(any_irq) |=> !irq_out;
    endproperty
    a_irq: assert property (p_irq) else $error("irq level wrong");
    property p_rsvd;
        mode_reserved |-> iface_select[1:0] == 2'b11;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved decode wrong");
    c_run: cover property (state == smp_pkg::ST_RUN && rx_pin_oe);
    c_irq_hi: cover property (pol && irq_out);
    c_tx: cover property (txen_rise ##[1:20] txen_fall);
    c_wb: cover property (wr_go ##3 wb_ack_o);

endmodule

`default_nettype wire

// ===== tb/smp_mac_model.sv
// mac and management station model facing the strap and mii pins
`timescale 1ns/10ps
`default_nettype none
module smp_mac_model (
    // clock
    input wire logic ref_clk,
    // shared receive pins
    input wire smp_pkg::smp_mii_rx_t rx_pin_out,
    input wire logic rx_pin_oe,
    input wire smp_pkg::smp_mii_rx_t pulls,
    output smp_pkg::smp_mii_rx_t rx_pin_in,
    // transmit pins toward the device
    output logic txen_pin,
    output logic [3:0] txd_pin,
    // management pins
    input wire logic mdio_out,
    input wire logic mdio_oe,
    output logic mdc_pin,
    output logic mdio_in
);
    logic st_drive = 1'b0;
    logic st_bit = 1'b1;
    // pull resistors win whenever the device lets go of the shared pins
    assign rx_pin_in = rx_pin_oe ? rx_pin_out : pulls;
    // line idles high through its pull-up, so a released line never shows stale data
    assign mdio_in = st_drive ? st_bit : (mdio_oe ? mdio_out : 1'b1);
    // idle levels at time zero
    initial begin
        txen_pin = 1'b0;
        txd_pin = 4'h0;
        mdc_pin = 1'b0;
    end
    // one nibble per call, held until the next call
    task automatic mac_tx(input logic en, input logic [3:0] nib);
        @(posedge ref_clk);
        txen_pin <= en;
        txd_pin <= nib;
    endtask
    // msb first, 800 ns per bit, mdc stands still outside the frame
    task automatic mgmt_shift(input logic [15:0] v);
        @(posedge ref_clk);
        for (int i = 15; i >= 0; i--) begin
            st_drive <= 1'b1;
            st_bit <= v[i];
            repeat (4) @(posedge ref_clk);
            mdc_pin <= 1'b1;
            repeat (4) @(posedge ref_clk);
            mdc_pin <= 1'b0;
        end
        repeat (4) @(posedge ref_clk);
        st_drive <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== tb/smp_top_tb.sv
// self-checking bench for the strap latch and mii pin roles block
`timescale 1ns/10ps
`default_nettype none
module smp_top_tb;
    localparam int HALF = 2;
    // clock, reset and bus master
    logic ref_clk = 1'b0, nrst = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic wb_ack_o;
    // pins and core side
    smp_pkg::smp_mii_rx_t pulls = 6'h00, core_rx = 6'h00, rx_pin_in, rx_pin_out;
    logic [1:0] cfg_lo_pin = 2'h0;
    logic rx_pin_oe, txen_pin, mdc_pin, mdio_in, mdio_out, mdio_oe, rxc_out, txc_out;
    logic irq_out, core_tx_en, mode_reserved;
    logic [3:0] txd_pin, core_tx_data;
    logic [4:0] mgmt_bus_address;
    logic [2:0] iface_select;
    int failures = 0, checks_done = 0;

    always #50 ref_clk = ~ref_clk;

    smp_top #(.CLK_HALF(HALF)) smp_top_inst (.ref_clk(ref_clk), .nrst(nrst),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .rx_pin_in(rx_pin_in), .rx_pin_out(rx_pin_out), .rx_pin_oe(rx_pin_oe),
        .cfg_lo_pin(cfg_lo_pin), .txen_pin(txen_pin), .txd_pin(txd_pin),
        .rxc_out(rxc_out), .txc_out(txc_out), .mdc_pin(mdc_pin), .mdio_in(mdio_in),
        .mdio_out(mdio_out), .mdio_oe(mdio_oe), .irq_out(irq_out), .core_rx(core_rx),
        .core_tx_en(core_tx_en), .core_tx_data(core_tx_data),
        .mgmt_bus_address(mgmt_bus_address), .iface_select(iface_select),
        .mode_reserved(mode_reserved));

    smp_mac_model smp_mac_model_inst (.ref_clk(ref_clk), .rx_pin_out(rx_pin_out),
        .rx_pin_oe(rx_pin_oe), .pulls(pulls), .rx_pin_in(rx_pin_in), .txen_pin(txen_pin),
        .txd_pin(txd_pin), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .mdc_pin(mdc_pin),
        .mdio_in(mdio_in));

    // ========================================================
    // verdict and comparisons
    task print_verdict;
        if (failures == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic check_bit(input logic seen, input logic exp);
        check({31'h0, seen}, {31'h0, exp});
    endtask

    // ========================================================
    // bus cycle: request held until ack is sampled, then released
    task automatic wb_xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
            input logic [3:0] s, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (n >= 50) begin
            check_bit(wb_ack_o, 1'b1);
        end
    endtask
    // reset held for five cycles
    task automatic do_reset;
        nrst <= 1'b0;
        repeat (5) @(posedge ref_clk);
        nrst <= 1'b1;
    endtask

    // hang guard well beyond the expected run of under a thousand cycles
    initial begin
        #500000;
        failures++;
        print_verdict();
    end

    // ========================================================
    // main sequence
    initial begin
        logic [31:0] q;
        logic [2:0] c;
        // every strap code: address, select, duplex, isolate
        for (int i = 0; i < 8; i++) begin
            c = 3'(i);
            pulls <= {c[2], c == 3'h6, c[0], c[1], c[2], c[0]};
            cfg_lo_pin <= c[1:0];
            do_reset();
            repeat (2) @(posedge ref_clk);
            check_bit(rx_pin_oe, 1'b0);
            repeat (4) @(posedge ref_clk);
            check({27'h0, mgmt_bus_address}, {29'h0, c});
            check({29'h0, iface_select}, {29'h0, c});
            check_bit(mode_reserved, c[1] & c[0]);
            wb_xfer(8'h40, 1'b0, 32'h0, 4'h3, q);
            check(q, {23'h0, c[1] & c[0], 2'h0, c, c});
            wb_xfer(8'h00, 1'b0, 32'h0, 4'h3, q);
            check_bit(q[8], ~c[0]);
            check_bit(q[10], c == 3'h6);
            check_bit(rx_pin_oe, c != 3'h6);
            if (c == 3'h6) begin
                pulls <= 6'h3F ^ pulls;
                smp_mac_model_inst.mac_tx(1'b1, 4'hF);
                repeat (5) @(posedge ref_clk);
                check_bit(core_tx_en, 1'b0);
                check({27'h0, mgmt_bus_address}, 32'h6);
                smp_mac_model_inst.mac_tx(1'b0, 4'h0);
            end
        end
        // unmapped index reads zero and ignores writes
        wb_xfer(8'h14, 1'b1, 32'hFFFF, 4'h3, q);
        wb_xfer(8'h14, 1'b0, 32'h0, 4'h3, q);
        check(q, 32'h0);
        // interrupt: latched event, enable, polarity, clear
        wb_xfer(8'h6C, 1'b0, 32'h0, 4'h3, q);
        check(q, 32'h4);
        check_bit(irq_out, 1'b1);
        wb_xfer(8'h6C, 1'b1, 32'h400, 4'h2, q);
        repeat (2) @(posedge ref_clk);
        check_bit(irq_out, 1'b0);
        wb_xfer(8'h7C, 1'b1, 32'h200, 4'h2, q);
        repeat (2) @(posedge ref_clk);
        check_bit(irq_out, 1'b1);
        wb_xfer(8'h6C, 1'b1, 32'h404, 4'h3, q);
        repeat (2) @(posedge ref_clk);
        check_bit(irq_out, 1'b0);
        // transmit nibble crosses to the core and raises start and end events
        smp_mac_model_inst.mac_tx(1'b1, 4'hA);
        repeat (4) @(posedge ref_clk);
        check_bit(core_tx_en, 1'b1);
        check({28'h0, core_tx_data}, 32'hA);
        smp_mac_model_inst.mac_tx(1'b0, 4'h0);
        repeat (4) @(posedge ref_clk);
        wb_xfer(8'h6C, 1'b0, 32'h0, 4'h3, q);
        check(q, 32'h403);
        // receive nibble reaches the shared pins
        core_rx <= 6'h29;
        repeat (2) @(posedge ref_clk);
        check({26'h0, rx_pin_in}, 32'h29);
        // both mii clocks identical and toggling every half period
        check_bit(txc_out, rxc_out);
        c[0] = rxc_out;
        repeat (HALF) @(posedge ref_clk);
        check_bit(rxc_out, ~c[0]);
        // management bits captured in step with mdc, line never driven
        smp_mac_model_inst.mgmt_shift(16'hB5C3);
        repeat (6) @(posedge ref_clk);
        wb_xfer(8'h44, 1'b0, 32'h0, 4'h3, q);
        check(q, 32'hB5C3);
        check_bit(mdio_oe, 1'b0);
        check_bit(mdio_out, 1'b0);
        print_verdict();
    end
endmodule
`default_nettype wire
